/* logic/txil_pkg.sv */
/*
 Shared constants and types for the transmitter on/off interlock.
 Assumes a single 20 MHz core clock.
*/
package txil_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RESTART_MS = 100;
  localparam int unsigned RESTART_CYC = CLK_HZ / 1000 * RESTART_MS;
  localparam int CNT_W = 21;
  localparam int SYNC_W = 8;

  // Synchronised input vector bit positions
  localparam int IN_ON = 0;
  localparam int IN_OFF = 1;
  localparam int IN_HEALTHY = 2;
  localparam int IN_ILK_N = 3;
  localparam int IN_FAILSAFE_N = 4;
  localparam int IN_FS_EN = 5;
  localparam int IN_REMOTE_N = 6;
  localparam int IN_PFAIL_N = 7;

  // Synchroniser resets to the idle levels (power good, no remote off,
  // healthy supervisor); zeros there would fake an off command at start
  localparam logic [SYNC_W-1:0] SYNC_RESET = 8'hC4;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } txil_sync_type;

endpackage

/* logic/txil_sync_if.sv */
/*
 Carries synchronised inputs from the synchroniser to the core.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface txil_sync_if;
  import txil_pkg::*;
  logic [SYNC_W-1:0] sync;
  modport src (output sync);
  modport dst (input sync);
endinterface

/* logic/txil_sync.sv */
/*
 Two-stage synchroniser for all asynchronous inputs but the supply-disable request.
 Assumes inputs may change at any time relative to core_clk.
*/
`timescale 1ns/1ps
module txil_sync
  import txil_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_q_n,
  input wire logic [SYNC_W-1:0] raw,
  txil_sync_if.src out
);

  txil_sync_type st_q;
  txil_sync_type st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      st_q <= '{s1: SYNC_RESET, s2: SYNC_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign out.sync = st_q.s2;

endmodule // txil_sync

/* logic/txil_top.sv */
/*
 Transmitter on/off interlock: turn-on stretcher, latching contactor relay,
 supply disable and system mute outputs.
 Assumes all inputs are asynchronous levels and core_clk runs at 20 MHz.
*/
`timescale 1ns/1ps
module txil_top
  import txil_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tx_on_req,
  input wire logic tx_off_req,
  input wire logic supervisor_healthy,
  input wire logic ext_interlock_n,
  input wire logic failsafe_n,
  input wire logic failsafe_enable,
  input wire logic remote_shutdown_n,
  input wire logic power_fail_n,
  input wire logic supervisor_supply_disable,
  output logic tx_restart,
  output logic contactor_set_n,
  output logic contactor_reset,
  output logic contactor_on_status,
  output logic contactor_on_n,
  output logic contactor_enable_n,
  output logic supply_disable,
  output logic system_mute
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_q_n;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q_n = rst_sync_q[1];

  // ****************************************
  // Input synchronisation
  // ****************************************
  txil_sync_if sif ();
  logic [SYNC_W-1:0] raw;

  // Pack the level inputs for the shared two-stage synchroniser
  always_comb begin
    raw = '0;
    raw[IN_ON] = tx_on_req;
    raw[IN_OFF] = tx_off_req;
    raw[IN_HEALTHY] = supervisor_healthy;
    raw[IN_ILK_N] = ext_interlock_n;
    raw[IN_FAILSAFE_N] = failsafe_n;
    raw[IN_FS_EN] = failsafe_enable;
    raw[IN_REMOTE_N] = remote_shutdown_n;
    raw[IN_PFAIL_N] = power_fail_n;
  end

  txil_sync u_sync (
    .core_clk(core_clk),
    .rst_q_n(rst_q_n),
    .raw(raw),
    .out(sif.src)
  );

  // Supply-disable request gets its own pair of flops; it only steers a
  // level output, so it need not stay aligned with the shared vector
  logic [1:0] dis_sync_q;
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      dis_sync_q <= 2'h0;
    end else begin
      dis_sync_q <= {dis_sync_q[0], supervisor_supply_disable};
    end
  end

  // ****************************************
  // Core state
  // ****************************************
  typedef struct packed {
    logic on_prev;
    logic [CNT_W-1:0] cnt;
    logic relay;
    logic restart;
    logic set_n;
    logic reset;
    logic status;
    logic on_n;
    logic en_n;
    logic sdis;
    logic mute;
  } txil_core_type;

  txil_core_type st_q;
  txil_core_type st_d;

  logic healthy;
  logic on_gated;
  logic off_any;
  logic ilk_ok;
  logic pgood;
  logic stretch_clr;
  logic pulse;
  logic fs_mute;

  // Gating and stretcher; a cleared stretcher also stops the restart and set that a
  // stray pulse would cause downstream
  always_comb begin
    healthy = sif.sync[IN_HEALTHY];
    ilk_ok = !sif.sync[IN_ILK_N];
    pgood = sif.sync[IN_PFAIL_N];
    on_gated = sif.sync[IN_ON] && healthy;
    off_any = (sif.sync[IN_OFF] && healthy)
      || !sif.sync[IN_REMOTE_N]
      || !ilk_ok;
    stretch_clr = !healthy && st_q.relay;
    pulse = st_q.cnt != '0;
    fs_mute = !sif.sync[IN_FAILSAFE_N]
      ? 1'b0
      : (sif.sync[IN_FS_EN] || !healthy);

    st_d = st_q;
    st_d.on_prev = on_gated;
    if (stretch_clr && !pulse) begin
      st_d.cnt = '0;
    end else if (on_gated && !st_q.on_prev && !pulse) begin
      st_d.cnt = CNT_W'(RESTART_CYC);
    end else if (pulse) begin
      st_d.cnt = st_q.cnt - CNT_W'(1);
    end

    // Off path wins over set so an open interlock always disengages
    if (off_any) begin
      st_d.relay = 1'b0;
    end else if (pulse && pgood && ilk_ok) begin
      st_d.relay = 1'b1;
    end

    st_d.restart = pulse && pgood;
    // Set needs the restart condition plus a closed interlock, so a power fail blocks it too
    st_d.set_n = !(pulse && pgood && ilk_ok);
    st_d.reset = off_any;
    st_d.status = st_d.relay;
    st_d.on_n = !st_d.relay;
    st_d.en_n = !(st_d.relay && pgood);
    st_d.sdis = !st_d.relay || (dis_sync_q[1] && healthy);
    st_d.mute = !st_d.relay || fs_mute;
  end

  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      st_q <= '{on_prev: 1'b0, cnt: '0, relay: 1'b0, restart: 1'b0,
        set_n: 1'b1, reset: 1'b0, status: 1'b0, on_n: 1'b1,
        en_n: 1'b1, sdis: 1'b1, mute: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  assign tx_restart = st_q.restart;
  assign contactor_set_n = st_q.set_n;
  assign contactor_reset = st_q.reset;
  assign contactor_on_status = st_q.status;
  assign contactor_on_n = st_q.on_n;
  assign contactor_enable_n = st_q.en_n;
  assign supply_disable = st_q.sdis;
  assign system_mute = st_q.mute;

  // ****************************************
  // Assertions
  // ****************************************
  property p_pulse_len;
    @(posedge core_clk) disable iff (!rst_q_n)
      $rose(pulse) |-> pulse [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("restart pulse too short");

  property p_on_gate;
    @(posedge core_clk) disable iff (!rst_q_n)
      $rose(pulse) |-> $past(healthy);
  endproperty
  a_on_gate: assert property (p_on_gate)
    else $error("pulse without healthy supervisor");

  property p_restart_pf;
    @(posedge core_clk) disable iff (!rst_q_n)
      !pgood |=> !tx_restart;
  endproperty
  a_restart_pf: assert property (p_restart_pf)
    else $error("restart during power fail");

  property p_restart_follow;
    @(posedge core_clk) disable iff (!rst_q_n)
      (pulse && pgood) |=> tx_restart;
  endproperty
  a_restart_follow: assert property (p_restart_follow)
    else $error("restart not forwarded");

  property p_set_ilk;
    @(posedge core_clk) disable iff (!rst_q_n)
      !ilk_ok |=> contactor_set_n && contactor_reset;
  endproperty
  a_set_ilk: assert property (p_set_ilk)
    else $error("set with open interlock");

  property p_ilk_off;
    @(posedge core_clk) disable iff (!rst_q_n)
      !ilk_ok |=> !contactor_on_status && system_mute;
  endproperty
  a_ilk_off: assert property (p_ilk_off)
    else $error("interlock did not disengage");

  property p_compl;
    @(posedge core_clk) disable iff (!rst_q_n)
      contactor_on_status != contactor_on_n;
  endproperty
  a_compl: assert property (p_compl)
    else $error("status outputs not complementary");

  property p_enable;
    @(posedge core_clk) disable iff (!rst_q_n)
      (!contactor_enable_n) |-> contactor_on_status;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable without contactor on");

  property p_clr;
    @(posedge core_clk) disable iff (!rst_q_n)
      (stretch_clr && !pulse) |=> !pulse;
  endproperty
  a_clr: assert property (p_clr)
    else $error("stretcher not held cleared");

  property p_sdis;
    @(posedge core_clk) disable iff (!rst_q_n)
      !contactor_on_status |-> supply_disable && system_mute;
  endproperty
  a_sdis: assert property (p_sdis)
    else $error("off contactor without disable/mute");

  property p_off;
    @(posedge core_clk) disable iff (!rst_q_n)
      off_any |=> contactor_reset && !contactor_on_status;
  endproperty
  a_off: assert property (p_off)
    else $error("off request ignored");

  // Remote off shares the off path with the local request
  property p_remote_off;
    @(posedge core_clk) disable iff (!rst_q_n)
      !sif.sync[IN_REMOTE_N] |=> contactor_reset && !contactor_on_status;
  endproperty
  a_remote_off: assert property (p_remote_off)
    else $error("remote off ignored");

  property p_fs_mute;
    @(posedge core_clk) disable iff (!rst_q_n)
      (sif.sync[IN_FAILSAFE_N] && sif.sync[IN_FS_EN]) |=> system_mute;
  endproperty
  a_fs_mute: assert property (p_fs_mute)
    else $error("open failsafe did not mute");

  property p_fs_failed;
    @(posedge core_clk) disable iff (!rst_q_n)
      (sif.sync[IN_FAILSAFE_N] && !healthy) |=> system_mute;
  endproperty
  a_fs_failed: assert property (p_fs_failed)
    else $error("failsafe gate off with failed supervisor");

  property p_sdis_req;
    @(posedge core_clk) disable iff (!rst_q_n)
      (dis_sync_q[1] && healthy) |=> supply_disable;
  endproperty
  a_sdis_req: assert property (p_sdis_req)
    else $error("supervisor disable request ignored");

  property p_sdis_gate;
    @(posedge core_clk) disable iff (!rst_q_n)
      (st_d.relay && !healthy) |=> !supply_disable;
  endproperty
  a_sdis_gate: assert property (p_sdis_gate)
    else $error("disable request passed from failed supervisor");

  property p_enable_pf;
    @(posedge core_clk) disable iff (!rst_q_n)
      !pgood |=> contactor_enable_n;
  endproperty
  a_enable_pf: assert property (p_enable_pf)
    else $error("contactor enabled during power fail");

  property p_set_follow;
    @(posedge core_clk) disable iff (!rst_q_n)
      (pulse && pgood && ilk_ok) |=> !contactor_set_n;
  endproperty
  a_set_follow: assert property (p_set_follow)
    else $error("restart did not drive the set input");

  // Latching relay moves only on a set pulse or an off condition
  property p_hold;
    @(posedge core_clk) disable iff (!rst_q_n)
      (!off_any && !pulse) |=> $stable(contactor_on_status);
  endproperty
  a_hold: assert property (p_hold)
    else $error("relay changed without a pulse");

  property p_clr_restart;
    @(posedge core_clk) disable iff (!rst_q_n)
      (stretch_clr && !pulse) |=> !pulse ##1 !tx_restart;
  endproperty
  a_clr_restart: assert property (p_clr_restart)
    else $error("restart while stretcher held cleared");

endmodule // txil_top

/* testbench/txil_master_model.sv */
/*
 Model of the supervising controller and the remote control interface.
 Assumes the bench changes its levels only just after a falling edge.
*/
`timescale 1ns/1ps
module txil_master_model (
  input wire logic core_clk,
  output logic tx_on_req,
  output logic tx_off_req,
  output logic supervisor_healthy,
  output logic supervisor_supply_disable,
  output logic ext_interlock_n,
  output logic failsafe_n,
  output logic failsafe_enable,
  output logic remote_shutdown_n
);
  // Idle levels: healthy supervisor, no requests, external loops closed
  initial begin
    tx_on_req = 1'h0;
    tx_off_req = 1'h0;
    supervisor_healthy = 1'h1;
    supervisor_supply_disable = 1'h0;
    ext_interlock_n = 1'h0;
    failsafe_n = 1'h0;
    failsafe_enable = 1'h1;
    remote_shutdown_n = 1'h1;
  end

  // Button press: held four cycles so it always survives the synchroniser
  task automatic press_on();
    @(negedge core_clk);
    tx_on_req = 1'h1;
    repeat (4) @(negedge core_clk);
    tx_on_req = 1'h0;
  endtask
endmodule // txil_master_model

/* testbench/transmitter_on_off_interlock_tb_top.sv */
/*
 Self-checking bench for the transmitter on/off interlock.
 Assumes the partner model drives the supervisor and remote lines.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module transmitter_on_off_interlock_tb_top;
  import txil_pkg::*;
  logic core_clk, rst_n, power_fail_n;
  logic on_r, off_r, hl, sd, ilk, fs, fse, rem;
  logic tx_restart, contactor_set_n, contactor_reset, contactor_on_status;
  logic contactor_on_n, contactor_enable_n, supply_disable, system_mute;
  logic [7:0] outs;
  int miscompares = 0;
  int total_checks = 0;
  assign outs = {tx_restart, contactor_set_n, contactor_reset,
    contactor_on_status, contactor_on_n, contactor_enable_n,
    supply_disable, system_mute};

  // ***********************************
  // Clock, partner and design
  // ***********************************
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  txil_master_model pm (.core_clk(core_clk), .tx_on_req(on_r),
    .tx_off_req(off_r), .supervisor_healthy(hl),
    .supervisor_supply_disable(sd), .ext_interlock_n(ilk),
    .failsafe_n(fs), .failsafe_enable(fse), .remote_shutdown_n(rem));
  txil_top dut (.core_clk(core_clk), .rst_n(rst_n), .tx_on_req(on_r),
    .tx_off_req(off_r), .supervisor_healthy(hl), .ext_interlock_n(ilk),
    .failsafe_n(fs), .failsafe_enable(fse), .remote_shutdown_n(rem),
    .power_fail_n(power_fail_n), .supervisor_supply_disable(sd),
    .tx_restart(tx_restart), .contactor_set_n(contactor_set_n),
    .contactor_reset(contactor_reset),
    .contactor_on_status(contactor_on_status),
    .contactor_on_n(contactor_on_n),
    .contactor_enable_n(contactor_enable_n),
    .supply_disable(supply_disable), .system_mute(system_mute));

  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Six cycles covers the three-edge input latency with margin
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask

  // Reset also ends a running stretch, which is far too long to wait out
  task automatic do_reset();
    @(negedge core_clk);
    rst_n = 1'h0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'h1;
    settle();
    `CHK(outs, 8'h4F)
  endtask

  // ***********************************
  // Scenarios
  // ***********************************
  task automatic t_turn_on();
    do_reset();
    pm.press_on();
    settle();
    `CHK(outs, 8'h90)
    pm.press_on(); // Retrigger while the stretch runs is refused
    repeat (20000) @(negedge core_clk);
    `CHK(outs, 8'h90)
    // Partner lines are variables of the model, so they are set there
    pm.failsafe_enable = 1'h0;
    pm.failsafe_n = 1'h1;
    settle();
    `CHK(outs, 8'h90)
    pm.failsafe_enable = 1'h1;
    settle();
    `CHK(outs, 8'h91)
    pm.failsafe_n = 1'h0;
    pm.supervisor_supply_disable = 1'h1;
    settle();
    `CHK(outs, 8'h92)
    pm.supervisor_supply_disable = 1'h0;
    power_fail_n = 1'h0;
    settle();
    `CHK(tx_restart, 1'h0)
    `CHK(contactor_enable_n, 1'h1)
    `CHK(contactor_set_n, 1'h1)
    `CHK(contactor_on_status, 1'h1)
    power_fail_n = 1'h1;
    pm.tx_off_req = 1'h1;
    settle();
    `CHK(outs, 8'hAF)
    pm.tx_off_req = 1'h0;
  endtask

  task automatic t_remote_off();
    do_reset();
    pm.press_on();
    settle();
    pm.remote_shutdown_n = 1'h0;
    settle();
    `CHK(outs, 8'hAF)
    pm.remote_shutdown_n = 1'h1;
  endtask

  // Interlock open at turn-on blocks the set and forces the reset
  task automatic t_interlock();
    do_reset();
    pm.ext_interlock_n = 1'h1;
    pm.press_on();
    settle();
    `CHK(outs, 8'hEF)
    pm.ext_interlock_n = 1'h0;
    settle();
    `CHK(outs, 8'h90)
    pm.ext_interlock_n = 1'h1;
    settle();
    `CHK(outs, 8'hEF)
    pm.ext_interlock_n = 1'h0;
  endtask

  // A failed supervisor is ignored, but failsafe muting stays live
  task automatic t_failed_supervisor();
    do_reset();
    pm.supervisor_healthy = 1'h0;
    pm.press_on();
    settle();
    `CHK(outs, 8'h4F)
    pm.supervisor_healthy = 1'h1;
    pm.press_on();
    settle();
    pm.supervisor_healthy = 1'h0;
    pm.supervisor_supply_disable = 1'h1;
    pm.tx_off_req = 1'h1;
    pm.failsafe_enable = 1'h0;
    pm.failsafe_n = 1'h1;
    settle();
    `CHK(outs, 8'h91)
    pm.supervisor_healthy = 1'h1;
    pm.supervisor_supply_disable = 1'h0;
    pm.tx_off_req = 1'h0;
    pm.failsafe_enable = 1'h1;
    pm.failsafe_n = 1'h0;
  endtask

  // Power failure at turn-on holds back both the restart and the set;
  // the stretch keeps running, so both appear once power returns
  task automatic t_power_fail();
    do_reset();
    power_fail_n = 1'h0;
    pm.press_on();
    settle();
    `CHK(outs, 8'h4F)
    power_fail_n = 1'h1;
    settle();
    `CHK(outs, 8'h90)
  endtask

  // ***********************************
  // Main sequence and watchdog
  // ***********************************
  initial begin
    rst_n = 1'h0;
    power_fail_n = 1'h1;
    t_turn_on();
    t_remote_off();
    t_interlock();
    t_failed_supervisor();
    t_power_fail();
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end
endmodule // transmitter_on_off_interlock_tb_top
